// ===== hw/rx_mac_pkg.sv
// Shared constants for the receive queue, frame filter and MAC control word block.
package rx_mac_pkg;
  // Directly addressed registers on the processor port.
  localparam logic [9:0] HIGH_MARK_OFS      = 10'h15B;
  localparam logic [9:0] EVENT_ENABLE_OFS   = 10'h15C;
  localparam logic [9:0] LATCHED_EVENTS_OFS = 10'h15D;
  localparam logic [9:0] ACCEPT_FILTER_OFS  = 10'h15E;
  // Indirect access window for the MAC register space.
  localparam logic [9:0] IND_RD_ADDR_HI_OFS = 10'h0A0;
  localparam logic [9:0] IND_RD_ADDR_LO_OFS = 10'h0A1;
  localparam logic [9:0] IND_WR_ADDR_HI_OFS = 10'h0A2;
  localparam logic [9:0] IND_WR_ADDR_LO_OFS = 10'h0A3;
  localparam logic [9:0] IND_DATA0_OFS      = 10'h0A4;
  localparam logic [15:0] MAC_CONTROL_IND   = 16'h0000;
  // Reset values.
  localparam logic [7:0]  HIGH_MARK_RST     = 8'h3A;
  localparam logic [7:0]  EVENT_ENABLE_RST  = 8'h00;
  localparam logic [7:0]  ACCEPT_FILTER_RST = 8'h00;
  localparam logic [31:0] MAC_CONTROL_RST   = 32'h00000000;
  // Event enable bit positions.
  localparam int EN_FIFO_OVR  = 3;
  localparam int EN_QUEUE_OVR = 2;
  localparam int EN_LOW_MARK  = 1;
  localparam int EN_HIGH_MARK = 0;
  // Latched event bit positions; high and low sit opposite to the enables.
  localparam int LS_FIFO_OVR  = 3;
  localparam int LS_QUEUE_OVR = 2;
  localparam int LS_HIGH_MARK = 1;
  localparam int LS_LOW_MARK  = 0;
  // Accept filter bit positions.
  localparam int FLT_NONPAUSE = 6;
  localparam int FLT_CTRL     = 5;
  localparam int FLT_LENGTH   = 4;
  localparam int FLT_CHECKSUM = 3;
  localparam int FLT_ODD_BITS = 2;
  localparam int FLT_PHY_ERR  = 1;
  localparam int FLT_BCAST    = 0;
  // MAC control word bit positions.
  localparam int CW_HEARTBEAT_OFF = 28;
  localparam int CW_PORT_CHOICE   = 27;
  localparam int CW_SELF_RX_BLOCK = 23;
  localparam int CW_LOOPBACK      = 21;
  localparam int CW_FULL_DUPLEX   = 20;
  localparam int CW_LATE_COL_RTY  = 12;
  // Watermark granule: 32 packets of 2048 bytes.
  localparam int unsigned MARK_PACKETS    = 32;
  localparam int unsigned MARK_PKT_BYTES  = 2048;
  localparam int unsigned MARK_UNIT_BYTES = MARK_PACKETS * MARK_PKT_BYTES;
  localparam int unsigned MARK_SHIFT      = $clog2(MARK_UNIT_BYTES);
  // Receive data FIFO shape.
  localparam int FIFO_WIDTH = 10;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_FRAME = 2'b01,
    RX_DROP  = 2'b11
  } rx_state_t;
endpackage

// ===== hw/rx_queue_mac.sv
// Receive frame filter, receive data FIFO, queue watermark events and MAC control word.
`timescale 1ns/1ps

// Synchronous FIFO with registered full and empty flags.
module rx_byte_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             full_q;
  logic             empty_q;
  logic             push;
  logic             pop;
  logic [AW:0]      count_d;

  assign push      = in_valid && !full_q;
  assign pop       = out_ready && !empty_q;
  assign in_ready  = !full_q;
  assign out_valid = !empty_q;
  assign out_data  = mem[rd_ptr_q];

  // Occupancy follows pushes and pops; flags are registered with it.
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      full_q   <= 1'b0;
      empty_q  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      full_q  <= (count_d == (AW+1)'(DEPTH));
      empty_q <= (count_d == '0);
    end
  end

  // Storage carries no reset, so it maps onto plain RAM.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end
endmodule

module rx_queue_mac #(
  parameter int ADDR_W  = 10,
  parameter int FILL_W  = 24,
  parameter int F_DEPTH = rx_mac_pkg::FIFO_DEPTH
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Processor port.
  input  wire logic              cpu_cs,
  input  wire logic              cpu_rd,
  input  wire logic              cpu_wr,
  input  wire logic [ADDR_W-1:0] cpu_addr,
  input  wire logic [7:0]        cpu_wdata,
  output logic [7:0]             cpu_rdata,
  // Receive byte stream from the PHY side, status valid with the last byte.
  input  wire logic              phy_rx_valid,
  input  wire logic [7:0]        phy_rx_data,
  input  wire logic              phy_rx_last,
  input  wire logic              frm_ctrl,
  input  wire logic              frm_pause,
  input  wire logic              frm_length_err,
  input  wire logic              frm_checksum_err,
  input  wire logic              frm_odd_bits,
  input  wire logic              frm_phy_err,
  input  wire logic              frm_broadcast,
  input  wire logic              frm_runt,
  input  wire logic              frm_collided,
  // Transmit byte stream from the MAC transmitter.
  input  wire logic              mac_tx_en,
  input  wire logic [7:0]        mac_tx_data,
  input  wire logic              mac_tx_last,
  output logic                   phy_tx_en,
  output logic [7:0]             phy_tx_data,
  // Receive data toward the memory queue.
  output logic [7:0]             q_data,
  output logic                   q_last,
  output logic                   q_keep,
  output logic                   q_valid,
  input  wire logic              q_ready,
  // Queue level and events from the memory controller.
  input  wire logic [FILL_W-1:0] queue_fill,
  input  wire logic [7:0]        low_mark_level,
  input  wire logic              queue_overflow,
  // MAC control outputs.
  output logic                   heartbeat_check_en,
  output logic                   full_duplex,
  output logic                   late_collision_retry,
  output logic                   port_choice,
  output logic                   rx_irq
);
  localparam int FW = rx_mac_pkg::FIFO_WIDTH;

  logic [7:0]        high_watermark_level_q;
  logic [7:0]        event_enable_q;
  logic [3:0]        latched_q;
  logic [3:0]        latched_d;
  logic [7:0]        accept_filter_q;
  logic [31:0]       mac_control_word_q;
  logic [15:0]       ind_rd_addr_q;
  logic [15:0]       ind_wr_addr_q;
  logic [7:0]        ind_data_q [4];
  logic [7:0]        cpu_rdata_q;
  logic              irq_q;
  logic [FILL_W-1:0] fill_prev_q;
  logic              wr_hit;
  logic              rd_hit;
  logic [7:0]        rd_mux;
  logic              rd_events;

  assign wr_hit    = cpu_cs && cpu_wr;
  assign rd_hit    = cpu_cs && cpu_rd;
  assign rd_events = rd_hit && (cpu_addr == ADDR_W'(rx_mac_pkg::LATCHED_EVENTS_OFS));

  // Direct configuration registers written by the processor.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_watermark_level_q <= rx_mac_pkg::HIGH_MARK_RST;
      event_enable_q         <= rx_mac_pkg::EVENT_ENABLE_RST;
      accept_filter_q        <= rx_mac_pkg::ACCEPT_FILTER_RST;
    end else if (wr_hit) begin
      case (cpu_addr)
        ADDR_W'(rx_mac_pkg::HIGH_MARK_OFS):     high_watermark_level_q <= cpu_wdata;
        ADDR_W'(rx_mac_pkg::EVENT_ENABLE_OFS):  event_enable_q         <= {4'h0, cpu_wdata[3:0]};
        ADDR_W'(rx_mac_pkg::ACCEPT_FILTER_OFS): accept_filter_q        <= {1'b0, cpu_wdata[6:0]};
        default: ;
      endcase
    end
  end

  // Indirect window: address pairs and a four-byte staging word.
  // indirect read: address then data; indirect write: data then address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ind_rd_addr_q      <= 16'h0000;
      ind_wr_addr_q      <= 16'h0000;
      mac_control_word_q <= rx_mac_pkg::MAC_CONTROL_RST;
      for (int i = 0; i < 4; i++) begin
        ind_data_q[i] <= 8'h00;
      end
    end else if (wr_hit) begin
      case (cpu_addr)
        ADDR_W'(rx_mac_pkg::IND_RD_ADDR_HI_OFS): ind_rd_addr_q[15:8] <= cpu_wdata;
        ADDR_W'(rx_mac_pkg::IND_WR_ADDR_HI_OFS): ind_wr_addr_q[15:8] <= cpu_wdata;
        ADDR_W'(rx_mac_pkg::IND_RD_ADDR_LO_OFS): begin
          // Writing the low read address fetches the word into the staging bytes.
          ind_rd_addr_q[7:0] <= cpu_wdata;
          if ({ind_rd_addr_q[15:8], cpu_wdata} == rx_mac_pkg::MAC_CONTROL_IND) begin
            {ind_data_q[0], ind_data_q[1], ind_data_q[2], ind_data_q[3]} <= mac_control_word_q;
          end else begin
            {ind_data_q[0], ind_data_q[1], ind_data_q[2], ind_data_q[3]} <= 32'h00000000;
          end
        end
        ADDR_W'(rx_mac_pkg::IND_WR_ADDR_LO_OFS): begin
          // Writing the low write address commits the staged word.
          ind_wr_addr_q[7:0] <= cpu_wdata;
          if ({ind_wr_addr_q[15:8], cpu_wdata} == rx_mac_pkg::MAC_CONTROL_IND) begin
            mac_control_word_q <= {ind_data_q[0], ind_data_q[1], ind_data_q[2], ind_data_q[3]};
          end
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (cpu_addr == ADDR_W'(rx_mac_pkg::IND_DATA0_OFS) + ADDR_W'(i)) begin
              ind_data_q[i] <= cpu_wdata;
            end
          end
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 8'h00;
    case (cpu_addr)
      ADDR_W'(rx_mac_pkg::HIGH_MARK_OFS):      rd_mux = high_watermark_level_q;
      ADDR_W'(rx_mac_pkg::EVENT_ENABLE_OFS):   rd_mux = event_enable_q;
      ADDR_W'(rx_mac_pkg::LATCHED_EVENTS_OFS): rd_mux = {4'h0, latched_q};
      ADDR_W'(rx_mac_pkg::ACCEPT_FILTER_OFS):  rd_mux = accept_filter_q;
      ADDR_W'(rx_mac_pkg::IND_RD_ADDR_HI_OFS): rd_mux = ind_rd_addr_q[15:8];
      ADDR_W'(rx_mac_pkg::IND_RD_ADDR_LO_OFS): rd_mux = ind_rd_addr_q[7:0];
      ADDR_W'(rx_mac_pkg::IND_WR_ADDR_HI_OFS): rd_mux = ind_wr_addr_q[15:8];
      ADDR_W'(rx_mac_pkg::IND_WR_ADDR_LO_OFS): rd_mux = ind_wr_addr_q[7:0];
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (cpu_addr == ADDR_W'(rx_mac_pkg::IND_DATA0_OFS) + ADDR_W'(i)) begin
            rd_mux = ind_data_q[i];
          end
        end
      end
    endcase
  end

  // Read data is held until the next read strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpu_rdata_q <= 8'h00;
    end else if (rd_hit) begin
      cpu_rdata_q <= rd_mux;
    end
  end
  assign cpu_rdata = cpu_rdata_q;

  // ---- Receive source selection and filter ----
  logic       cw_loop;
  logic       src_valid;
  logic [7:0] src_data;
  logic       src_last;
  logic       reject;
  logic       fifo_in_ready;
  logic       fifo_in_valid;
  logic [FW-1:0] fifo_in_data;
  logic [FW-1:0] fifo_out_data;
  logic       fifo_overrun;
  rx_mac_pkg::rx_state_t rx_state_q;

  assign cw_loop = mac_control_word_q[rx_mac_pkg::CW_LOOPBACK];

  always_comb begin
    if (cw_loop) begin
      src_valid = mac_tx_en;
      src_data  = mac_tx_data;
      src_last  = mac_tx_last;
    end else if (mac_control_word_q[rx_mac_pkg::CW_SELF_RX_BLOCK] && mac_tx_en) begin
      src_valid = 1'b0;
      src_data  = phy_rx_data;
      src_last  = 1'b0;
    end else begin
      src_valid = phy_rx_valid;
      src_data  = phy_rx_data;
      src_last  = phy_rx_last;
    end
  end

  // Frame verdict; looped frames carry clean status.  A PHY error passes if either error bit allows it.
  always_comb begin
    reject = 1'b0;
    if (!cw_loop) begin
      if (frm_ctrl && !accept_filter_q[rx_mac_pkg::FLT_CTRL]) reject = 1'b1;
      if (frm_ctrl && !frm_pause && !accept_filter_q[rx_mac_pkg::FLT_NONPAUSE]) reject = 1'b1;
      if (frm_length_err && !accept_filter_q[rx_mac_pkg::FLT_LENGTH]) reject = 1'b1;
      if (frm_checksum_err && !accept_filter_q[rx_mac_pkg::FLT_CHECKSUM]) reject = 1'b1;
      if (frm_phy_err && !accept_filter_q[rx_mac_pkg::FLT_PHY_ERR]
          && !accept_filter_q[rx_mac_pkg::FLT_CHECKSUM]) reject = 1'b1;
      if (frm_odd_bits && !frm_runt && !frm_collided
          && !accept_filter_q[rx_mac_pkg::FLT_ODD_BITS]) reject = 1'b1;
      if (frm_broadcast && !accept_filter_q[rx_mac_pkg::FLT_BCAST]) reject = 1'b1;
    end
  end

  // The verdict only exists at the last byte, so it travels as a keep flag with it.
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = {src_last, !(src_last && reject), src_data};
    fifo_overrun  = 1'b0;
    case (rx_state_q)
      rx_mac_pkg::RX_DROP: begin
        // After an overrun only a closing marker is stored, always marked discard.
        fifo_in_valid = src_valid && src_last && fifo_in_ready;
        fifo_in_data  = {1'b1, 1'b0, src_data};
      end
      default: begin
        fifo_in_valid = src_valid;
        // byte lost to a full FIFO
        fifo_overrun  = src_valid && !fifo_in_ready;
      end
    endcase
  end

  // Frame tracking; a byte stream cannot be paused, so overrun drops the rest of the frame.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_state_q <= rx_mac_pkg::RX_IDLE;
    end else begin
      case (rx_state_q)
        rx_mac_pkg::RX_IDLE: begin
          if (fifo_overrun && !src_last) rx_state_q <= rx_mac_pkg::RX_DROP;
          else if (src_valid && !src_last) rx_state_q <= rx_mac_pkg::RX_FRAME;
        end
        rx_mac_pkg::RX_FRAME: begin
          if (fifo_overrun && !src_last) rx_state_q <= rx_mac_pkg::RX_DROP;
          else if (src_valid && src_last) rx_state_q <= rx_mac_pkg::RX_IDLE;
        end
        rx_mac_pkg::RX_DROP: begin
          if (src_valid && src_last) rx_state_q <= rx_mac_pkg::RX_IDLE;
        end
        default: rx_state_q <= rx_mac_pkg::RX_IDLE;
      endcase
    end
  end

  rx_byte_fifo #(
    .WIDTH (FW),
    .DEPTH (F_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (fifo_in_data),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (q_valid),
    .out_ready (q_ready)
  );

  assign q_last = fifo_out_data[9];
  assign q_keep = fifo_out_data[8];
  assign q_data = fifo_out_data[7:0];

  // ---- Watermark crossings and latched events ----
  logic [FILL_W-1:0] high_mark_bytes;
  logic [FILL_W-1:0] low_mark_bytes;
  logic              high_cross;
  logic              low_cross;
  logic [3:0]        en_mapped;

  assign high_mark_bytes = FILL_W'({high_watermark_level_q, {rx_mac_pkg::MARK_SHIFT{1'b0}}});
  assign low_mark_bytes  = FILL_W'({low_mark_level, {rx_mac_pkg::MARK_SHIFT{1'b0}}});
  assign high_cross = (fill_prev_q < high_mark_bytes) && (queue_fill >= high_mark_bytes);
  assign low_cross  = (fill_prev_q >= low_mark_bytes) && (queue_fill < low_mark_bytes);

  // The previous level tracks the input during reset too, so release never fakes a crossing.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fill_prev_q <= queue_fill;
    end else begin
      fill_prev_q <= queue_fill;
    end
  end

  // Clear on read, but an event in the read cycle survives into the next read.
  always_comb begin
    latched_d = rd_events ? 4'h0 : latched_q;
    if (fifo_overrun) latched_d[rx_mac_pkg::LS_FIFO_OVR] = 1'b1;
    if (queue_overflow) latched_d[rx_mac_pkg::LS_QUEUE_OVR] = 1'b1;
    if (high_cross) latched_d[rx_mac_pkg::LS_HIGH_MARK] = 1'b1;
    if (low_cross) latched_d[rx_mac_pkg::LS_LOW_MARK] = 1'b1;
  end

  assign en_mapped[rx_mac_pkg::LS_FIFO_OVR]  = event_enable_q[rx_mac_pkg::EN_FIFO_OVR];
  assign en_mapped[rx_mac_pkg::LS_QUEUE_OVR] = event_enable_q[rx_mac_pkg::EN_QUEUE_OVR];
  assign en_mapped[rx_mac_pkg::LS_HIGH_MARK] = event_enable_q[rx_mac_pkg::EN_HIGH_MARK];
  assign en_mapped[rx_mac_pkg::LS_LOW_MARK]  = event_enable_q[rx_mac_pkg::EN_LOW_MARK];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latched_q <= 4'h0;
      irq_q     <= 1'b0;
    end else begin
      latched_q <= latched_d;
      irq_q     <= |(latched_d & en_mapped);
    end
  end
  assign rx_irq = irq_q;

  // ---- MAC control outputs, registered ----
  logic       hb_en_q;
  logic       fdx_q;
  logic       lcr_q;
  logic       pc_q;
  logic       tx_en_q;
  logic [7:0] tx_data_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hb_en_q <= 1'b0;
      fdx_q   <= 1'b0;
      lcr_q   <= 1'b0;
      pc_q    <= 1'b0;
    end else begin
      hb_en_q <= !mac_control_word_q[rx_mac_pkg::CW_HEARTBEAT_OFF]
                 && !mac_control_word_q[rx_mac_pkg::CW_FULL_DUPLEX];
      fdx_q   <= mac_control_word_q[rx_mac_pkg::CW_FULL_DUPLEX];
      lcr_q   <= mac_control_word_q[rx_mac_pkg::CW_LATE_COL_RTY];
      pc_q    <= mac_control_word_q[rx_mac_pkg::CW_PORT_CHOICE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_en_q   <= 1'b0;
      tx_data_q <= 8'h00;
    end else begin
      tx_en_q   <= mac_tx_en && !cw_loop;
      tx_data_q <= cw_loop ? 8'h00 : mac_tx_data;
    end
  end

  assign heartbeat_check_en   = hb_en_q;
  assign full_duplex          = fdx_q;
  assign late_collision_retry = lcr_q;
  assign port_choice          = pc_q;
  assign phy_tx_en            = tx_en_q;
  assign phy_tx_data          = tx_data_q;
endmodule

// ===== sim/phy_model.sv
// Behavioural PHY-side source of received bytes and per-frame status.
`timescale 1ns/1ps
module phy_model (
  input wire logic   sys_clk,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_last,
  output logic [8:0] flags
);
  initial {rx_valid, rx_data, rx_last, flags} = '0;
  // Status is inverted on every byte but the last, and data and status are inverted between frames, so a stale value never passes for a fresh one.
  task automatic send(input int n, input logic [8:0] f);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      {rx_valid, rx_last, rx_data, flags} = {1'h1, i == n - 1, 8'(8'hA0 + i), (i == n - 1) ? f : ~f};
    end
    @(negedge sys_clk);
    {rx_valid, rx_last, rx_data, flags} = {2'h0, ~rx_data, ~flags};
  endtask
endmodule

// ===== sim/rx_queue_mac_monitor.sv
// Concurrent checks on the receive queue block ports, bound into rx_queue_mac.
`timescale 1ns/1ps
module rx_queue_mac_monitor #(
  parameter int ADDR_W = 10,
  parameter int FILL_W = 24
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cpu_cs,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [7:0] cpu_rdata,
  input wire logic phy_rx_valid,
  input wire logic mac_tx_en,
  input wire logic phy_tx_en,
  input wire logic [7:0] q_data,
  input wire logic q_last,
  input wire logic q_keep,
  input wire logic q_valid,
  input wire logic q_ready,
  input wire logic [FILL_W-1:0] queue_fill,
  input wire logic queue_overflow,
  input wire logic heartbeat_check_en,
  input wire logic full_duplex,
  input wire logic rx_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic quiet;
  // No event source is active; the level is judged stable inside each property.
  assign quiet = !queue_overflow && !phy_rx_valid && !mac_tx_en;
  // Transmit path and duplex.
  chk_tx_follows: assert property (phy_tx_en |-> $past(mac_tx_en))
    else $error("phy transmit without request");
  chk_duplex_hb: assert property (full_duplex |-> !heartbeat_check_en)
    else $error("heartbeat check on in full duplex");
  // Register port answers.
  chk_rdata_holds: assert property (!(cpu_cs && cpu_rd) |=> $stable(cpu_rdata))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (cpu_cs && cpu_rd && cpu_addr == 10'h3FF |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Interrupt request tracks latched events.
  chk_irq_cleared: assert property (
    cpu_cs && cpu_rd && cpu_addr == 10'h15D && quiet && $stable(queue_fill) |=> !rx_irq)
    else $error("interrupt stayed after status read");
  chk_irq_cause: assert property (
    !rx_irq && quiet && $stable(queue_fill) && !$past(cpu_cs && cpu_wr) |=> !rx_irq)
    else $error("interrupt without cause");
  // FIFO head toward the memory queue.
  chk_head_holds: assert property (
    q_valid && !q_ready |=> q_valid && $stable({q_data, q_last, q_keep}))
    else $error("stalled head changed");
  chk_head_source: assert property (
    $rose(q_valid) |-> $past(phy_rx_valid || mac_tx_en) || $past(phy_rx_valid || mac_tx_en, 2))
    else $error("head without pushed byte");
  cov_irq_read: cover property (rx_irq && cpu_cs && cpu_rd);
  cov_drop: cover property (q_valid && q_last && !q_keep);
  cov_stall: cover property (q_valid && !q_ready);
endmodule

bind rx_queue_mac rx_queue_mac_monitor #(.ADDR_W(ADDR_W), .FILL_W(FILL_W)) i_rx_queue_mac_monitor (
  .sys_clk, .rst, .cpu_cs, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_rdata, .phy_rx_valid, .mac_tx_en, .phy_tx_en,
  .q_data, .q_last, .q_keep, .q_valid, .q_ready, .queue_fill, .queue_overflow, .heartbeat_check_en,
  .full_duplex, .rx_irq);

// ===== sim/tb_top.sv
// Self-checking bench for the receive queue, frame filter and control word block.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'h0, rst = 1'h1, cpu_cs = 1'h0, cpu_rd = 1'h0, cpu_wr = 1'h0, mac_tx_en = 1'h0;
  logic mac_tx_last = 1'h0, q_ready = 1'h1, queue_overflow = 1'h0, last_keep;
  logic [9:0] cpu_addr = 10'h000;
  logic [7:0] cpu_wdata = 8'h00, cpu_rdata, phy_rx_data;
  logic [23:0] queue_fill = 24'h000000;
  logic [8:0] fl;
  logic [7:0] qd, ptd, last_data;
  logic phy_rx_valid, phy_rx_last, phy_tx_en, q_last, q_keep, q_valid, hb, fd, lcr, pc, rx_irq;
  int mismatches = 0, tests_run = 0, pops = 0;
  // Clock at 100 MHz.
  always #5 sys_clk = ~sys_clk;
  phy_model i_phy_model (.sys_clk, .rx_valid(phy_rx_valid), .rx_data(phy_rx_data), .rx_last(phy_rx_last), .flags(fl));
  rx_queue_mac i_rx_queue_mac (.sys_clk, .rst, .cpu_cs, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata,
    .phy_rx_valid, .phy_rx_data, .phy_rx_last, .frm_ctrl(fl[0]), .frm_pause(fl[1]), .frm_length_err(fl[2]),
    .frm_checksum_err(fl[3]), .frm_odd_bits(fl[4]), .frm_phy_err(fl[5]), .frm_broadcast(fl[6]), .frm_runt(fl[7]),
    .frm_collided(fl[8]), .mac_tx_en, .mac_tx_data(8'h5A), .mac_tx_last, .phy_tx_en, .phy_tx_data(ptd),
    .q_data(qd), .q_last, .q_keep, .q_valid, .q_ready, .queue_fill, .low_mark_level(8'h10), .queue_overflow,
    .heartbeat_check_en(hb), .full_duplex(fd), .late_collision_retry(lcr), .port_choice(pc), .rx_irq);
  // The verdict of a frame travels on its last word, so only those words are kept.
  always @(posedge sys_clk) if (q_valid && q_ready && q_last) {last_data, last_keep, pops} <= {qd, q_keep, pops + 1};
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk) {cpu_cs, cpu_wr, cpu_addr, cpu_wdata} = {2'h3, a, d};
    @(negedge sys_clk) {cpu_cs, cpu_wr} = 2'h0;
  endtask
  // One strobe cycle per read, since a second edge would clear the status again.
  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    @(negedge sys_clk) {cpu_cs, cpu_rd, cpu_addr} = {2'h3, a};
    @(negedge sys_clk) {cpu_cs, cpu_rd} = 2'h0;
    chk(cpu_rdata, e);
  endtask
  task automatic wl(input int n0, input logic e, input logic [7:0] d);
    for (int k = 0; k < 60 && pops == n0; k++) @(negedge sys_clk);
    chk(pops != n0, 1'h1);
    if (pops == n0) report_and_stop();
    chk(last_keep, e);
    chk(last_data, d);
  endtask
  task automatic iw(input logic [31:0] d);
    for (int i = 0; i < 4; i++) wr(10'h0A4 + 10'(i), d[31 - 8 * i -: 8]);
    wr(10'h0A2, 8'h00);
    wr(10'h0A3, 8'h00);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic t_regs();
    rc(10'h15B, 8'h3A);
    rc(10'h15C, 8'h00);
    rc(10'h3FF, 8'h00);
    wr(10'h15C, 8'hFF);
    rc(10'h15C, 8'h0F);
    wr(10'h15E, 8'hFF);
    rc(10'h15E, 8'h7F);
    $display("test registers done");
  endtask
  task automatic t_events();
    wr(10'h15C, 8'h04);
    @(negedge sys_clk) queue_overflow = 1'h1;
    @(negedge sys_clk) queue_overflow = 1'h0;
    chk(rx_irq, 1'h1);
    rc(10'h15D, 8'h04);
    chk(rx_irq, 1'h0);
    wr(10'h15C, 8'h01);
    @(negedge sys_clk) queue_fill = 24'h39FFFF;
    @(negedge sys_clk) queue_fill = 24'h3A0000;
    chk(rx_irq, 1'h0);
    @(negedge sys_clk) chk(rx_irq, 1'h1);
    rc(10'h15D, 8'h02);
    @(negedge sys_clk) queue_fill = 24'h000000;
    @(negedge sys_clk) chk(rx_irq, 1'h0);
    rc(10'h15D, 8'h01);
    $display("test events done");
  endtask
  // Stalling the drain side forces the FIFO to refuse bytes mid-frame.
  task automatic t_fifo();
    wr(10'h15C, 8'h08);
    q_ready = 1'h0;
    i_phy_model.send(40, 9'h000);
    chk(rx_irq, 1'h1);
    rc(10'h15D, 8'h08);
    q_ready = 1'h1;
    for (int k = 0; k < 60 && q_valid; k++) @(negedge sys_clk);
    chk(q_valid, 1'h0);
    if (q_valid) report_and_stop();
    $display("test fifo done");
  endtask
  // Each row holds frame status, filter setting and the expected keep flag.
  task automatic t_filter();
    int n;
    logic [17:0] row [18] = '{18'h08000, 18'h08003, 18'h04000, 18'h04005, 18'h02000, 18'h02009, 18'h12001,
      18'h01000, 18'h01011, 18'h00800, 18'h00821, 18'h00600, 18'h00641, 18'h00240, 18'h002C1, 18'h00001,
      18'h22001, 18'h04011};
    for (int i = 0; i < 18; i++) begin
      wr(10'h15E, row[i][8:1]);
      n = pops;
      i_phy_model.send(2, row[i][17:9]);
      wl(n, row[i][0], 8'hA1);
    end
    $display("test filter done");
  endtask
  task automatic t_ctrl();
    int n;
    iw(32'h10101000);
    chk({hb, fd, lcr, pc}, 4'h6);
    wr(10'h0A0, 8'h00);
    wr(10'h0A1, 8'h00);
    for (int i = 0; i < 3; i++) rc(10'h0A4 + 10'(i), 8'h10);
    iw(32'h10000000);
    chk({hb, fd}, 2'h0);
    iw(32'h00200000);
    n = pops;
    @(negedge sys_clk) {mac_tx_en, mac_tx_last} = 2'h3;
    @(negedge sys_clk) {mac_tx_en, mac_tx_last} = 2'h0;
    chk({phy_tx_en, ptd}, 9'h000);
    wl(n, 1'h1, 8'h5A);
    // Own-receive blocking: a frame from the PHY while the transmitter runs must not reach the queue.
    iw(32'h00800000);
    n = pops;
    mac_tx_en = 1'h1;
    i_phy_model.send(2, 9'h000);
    mac_tx_en = 1'h0;
    chk({q_valid, pops != n}, 2'h0);
    iw(32'h00000000);
    @(negedge sys_clk) mac_tx_en = 1'h1;
    @(negedge sys_clk) mac_tx_en = 1'h0;
    chk({phy_tx_en, hb, ptd}, 10'h35A);
    $display("test control done");
  endtask
  task automatic report_and_stop();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hold reset for twelve cycles, then run every scenario once.
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'h0;
    t_regs();
    t_events();
    t_fifo();
    t_filter();
    t_ctrl();
    report_and_stop();
  end
endmodule
